// >>> hdl/rwd_watchdog.sv
// Function
// (RULE1) 22-stage counter ticking every two oscillator periods
// (RULE2) four taps select detection period
// (RULE3) overflow raises nmi and drives fault low
// (RULE4) fault held until disable then clear code
// (RULE5) reset link holds fault, then resets chip
// (RULE6) reset link bit clears on reset
// (RULE7) tap field resets to shortest period
// (RULE8) enable resets set; disable needs clear-then-code
// (RULE9) setting enable bit alone re-enables
// (RULE10) counter runs while watchdog disabled
// (RULE11) clear code zeroes the counter
// (RULE12) reset and standby entry zero counter
// (RULE13) uncleared counter wraps through 22 stages
// (RULE14) counter halts in idle and stop
// (RULE15) counter runs while bus is released
// (RULE16) counting resumes enabled right after reset
// (RULE17) software clears before detection time elapses
// (RULE18) software clears counter before re-enabling
// (RULE19) interval-timer handler clears on every interrupt
// (RULE20) enable bit sits at mode bit 7
// (RULE21) other command values have no effect
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "rwd_defs.svh"

module rwd_watchdog #(
  parameter int HOLD_STATES = `RWD_HOLD_STATES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // chip power state and bus release, from outside this clock
  input wire logic standby_mode,
  input wire logic bus_grant_ack_n,
  // watchdog outputs
  output logic wd_irq,
  output logic wd_fault_out_n,
  output logic wd_chip_reset_req
);

  localparam int HOLD_CYCLES = HOLD_STATES * `RWD_OSC_PER_TICK;
  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

  initial begin
    if (HOLD_STATES < `RWD_HOLD_STATES_MIN || HOLD_STATES > `RWD_HOLD_STATES_MAX) begin
      $error("rwd_watchdog fault hold must be 8 to 20 states");
    end
  end

  rwd_pkg::rwd_mode_type wd_mode_reg;
  rwd_pkg::rwd_power_type powerSync;
  logic wdActive;
  logic tick;
  logic counterClear;
  logic overflow;
  logic standbyLast;
  logic [`RWD_COUNT_WIDTH-1:0] count;
  logic [HOLD_W-1:0] holdCount;

  // write channel holding
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic modeWrite;
  logic cmdWrite;
  logic [7:0] next_modeByte;

  function automatic logic known_addr(input logic [11:0] addr);
    known_addr = (addr == `RWD_MODE_OFFSET) || (addr == `RWD_COMMAND_OFFSET) ||
                 (addr == `RWD_STATUS_OFFSET) || (addr == `RWD_COUNT_OFFSET);
  endfunction : known_addr

  rwd_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn({standby_mode, ~bus_grant_ack_n}),
    .syncOut(powerSync)
  );

  // one tick every two oscillator periods
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= ~tick; // RULE1
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      standbyLast <= 1'b0;
    end else begin
      standbyLast <= powerSync.standby;
    end
  end

  // bus release does not enter the run condition on purpose
  assign counterClear = (cmdWrite && wData[7:0] == `RWD_CODE_CLEAR) ||
                        (powerSync.standby && !standbyLast); // RULE11 RULE12 RULE21

  rwd_counter #(
    .WIDTH(`RWD_COUNT_WIDTH)
  ) u_counter (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(tick),
    .clear(counterClear),
    .run(!powerSync.standby), // RULE14 RULE15 RULE10
    .tap(wd_mode_reg.tap),
    .count(count),
    .overflow(overflow)
  );

  // bus slave: address and data taken in either order
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign modeWrite = doWrite && awAddr == `RWD_MODE_OFFSET && wStrb[0];
  assign cmdWrite = doWrite && awAddr == `RWD_COMMAND_OFFSET && wStrb[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= {s_axi_awaddr[11:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end else if (!awHeld && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end else if (!wHeld && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RWD_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_addr(awAddr) ? `RWD_RESP_OKAY : `RWD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // mode register
  assign next_modeByte = wData[7:0] & `RWD_MODE_WMASK;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wd_mode_reg.enable <= 1'b1; // RULE8 RULE16
      wd_mode_reg.tap <= rwd_pkg::RWD_TAP_16; // RULE7
      wd_mode_reg.resetLink <= 1'b0; // RULE6
    end else if (modeWrite) begin
      wd_mode_reg.enable <= next_modeByte[`RWD_ENABLE_BIT]; // RULE20
      wd_mode_reg.tap <= rwd_pkg::rwd_tap_type'(next_modeByte[`RWD_TAP_LSB +: 2]);
      wd_mode_reg.resetLink <= next_modeByte[`RWD_RESET_LINK_BIT];
    end
  end

  // active state: cleared only by disable code with enable bit already low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wdActive <= 1'b1; // RULE16
    end else if (modeWrite && next_modeByte[`RWD_ENABLE_BIT]) begin
      wdActive <= 1'b1; // RULE9
    end else if (cmdWrite && wData[7:0] == `RWD_CODE_DISABLE && !wd_mode_reg.enable) begin
      wdActive <= 1'b0; // RULE8 RULE21
    end
  end

  // interrupt pulse on overflow while active
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wd_irq <= 1'b0;
    end else begin
      wd_irq <= overflow && wdActive; // RULE3 RULE10
    end
  end

  // fault pin: overflow sets, which wins over a same-cycle clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wd_fault_out_n <= 1'b1;
    end else if (overflow && wdActive) begin
      wd_fault_out_n <= 1'b0; // RULE3
    end else if (!wdActive && cmdWrite && wData[7:0] == `RWD_CODE_CLEAR) begin
      wd_fault_out_n <= 1'b1; // RULE4
    end
  end

  // reset link: hold fault low for a fixed number of states, then reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holdCount <= '0;
      wd_chip_reset_req <= 1'b0;
    end else if (!wd_mode_reg.resetLink || wd_fault_out_n) begin
      holdCount <= '0;
      wd_chip_reset_req <= 1'b0;
    end else if (holdCount == HOLD_W'(HOLD_CYCLES - 1)) begin
      wd_chip_reset_req <= 1'b1; // RULE5
    end else begin
      holdCount <= holdCount + HOLD_W'(1); // RULE5
    end
  end

  // read channel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RWD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known_addr({s_axi_araddr[11:2], 2'b00}) ? `RWD_RESP_OKAY
                                                              : `RWD_RESP_SLVERR;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `RWD_MODE_OFFSET: s_axi_rdata <= {24'h000000, wd_mode_reg.enable,
                                          wd_mode_reg.tap, 3'h0,
                                          wd_mode_reg.resetLink, 1'b0};
        `RWD_STATUS_OFFSET: s_axi_rdata <= {27'h0000000, powerSync.busGrantAck, wd_chip_reset_req,
                                            powerSync.standby, ~wd_fault_out_n,
                                            wdActive};
        `RWD_COUNT_OFFSET: s_axi_rdata <= {10'h000, count};
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : rwd_watchdog

`default_nettype wire

// >>> common/rwd_defs.svh
`ifndef RWD_DEFS_SVH
`define RWD_DEFS_SVH

// register byte offsets on the bus
`define RWD_MODE_OFFSET 12'h000
`define RWD_COMMAND_OFFSET 12'h004
`define RWD_STATUS_OFFSET 12'h008
`define RWD_COUNT_OFFSET 12'h00C

// mode register fields
`define RWD_ENABLE_BIT 7
`define RWD_TAP_LSB 5
`define RWD_RESET_LINK_BIT 1
`define RWD_MODE_RESET 8'h80
`define RWD_MODE_WMASK 8'hE2

// command codes
`define RWD_CODE_CLEAR 8'h4E
`define RWD_CODE_DISABLE 8'hB1

// counter geometry
`define RWD_COUNT_WIDTH 22
`define RWD_OSC_PER_TICK 2

// fault hold in states (one state = two oscillator periods)
`define RWD_HOLD_STATES_MIN 8
`define RWD_HOLD_STATES_MAX 20
`define RWD_HOLD_STATES 12

// axi responses
`define RWD_RESP_OKAY 2'h0
`define RWD_RESP_SLVERR 2'h2

`endif

// >>> common/rwd_pkg.sv
package rwd_pkg;

  typedef enum logic [1:0] {
    RWD_TAP_16 = 2'h0,
    RWD_TAP_18 = 2'h1,
    RWD_TAP_20 = 2'h2,
    RWD_TAP_22 = 2'h3
  } rwd_tap_type;

  typedef struct packed {
    logic enable;
    rwd_tap_type tap;
    logic resetLink;
  } rwd_mode_type;

  typedef struct packed {
    logic standby;
    logic busGrantAck;
  } rwd_power_type;

endpackage : rwd_pkg

// >>> hdl/rwd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rwd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial begin
    if (WIDTH < 1) $error("rwd_sync width must be positive");
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      syncOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          syncOut[i] <= stage3[i];
        end
      end
    end
  end

endmodule : rwd_sync

`default_nettype wire

// >>> hdl/rwd_counter.sv
`timescale 1ns/1ps
`default_nettype none

`include "rwd_defs.svh"

module rwd_counter #(
  parameter int WIDTH = `RWD_COUNT_WIDTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  input wire logic tick,
  input wire logic clear,
  input wire logic run,
  input wire rwd_pkg::rwd_tap_type tap,
  // state
  output logic [WIDTH-1:0] count,
  output logic overflow
);

  logic [WIDTH-1:0] next_count;
  logic tapCarry;

  initial begin
    if (WIDTH != `RWD_COUNT_WIDTH) $error("rwd_counter taps need 22 stages");
  end

  assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

  // carry into the selected stage: all bits below it set
  always_comb begin
    unique case (tap)
      rwd_pkg::RWD_TAP_16: tapCarry = &count[14:0];
      rwd_pkg::RWD_TAP_18: tapCarry = &count[16:0];
      rwd_pkg::RWD_TAP_20: tapCarry = &count[18:0];
      rwd_pkg::RWD_TAP_22: tapCarry = &count[20:0];
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0; // RULE12
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (clear) begin
        count <= '0; // RULE11 RULE12
      end else if (tick && run) begin // RULE14
        count <= next_count; // RULE1 RULE13
        overflow <= tapCarry; // RULE2
      end
    end
  end

endmodule : rwd_counter

`default_nettype wire

// >>> bench/rwd_watchdog_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module rwd_watchdog_monitor #(
  parameter int HOLD_STATES = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // watchdog outputs
  input wire logic wd_irq,
  input wire logic wd_fault_out_n,
  input wire logic wd_chip_reset_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic [16:0] sinceRst;
  logic [5:0] lowCnt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) sinceRst <= 17'h00000;
    else if (!sinceRst[16]) sinceRst <= sinceRst + 17'h00001;
  end

  // saturates so a long fault never wraps back into the legal window
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) lowCnt <= 6'h00;
    else if (wd_fault_out_n) lowCnt <= 6'h00;
    else if (lowCnt != 6'h3F) lowCnt <= lowCnt + 6'h01;
  end

  a_irq_one_cycle: assert property (wd_irq |=> !wd_irq)
    else $error("interrupt pulse longer than one cycle");
  a_irq_drops_fault: assert property (wd_irq |-> ##[0:2] !wd_fault_out_n)
    else $error("fault output not driven low on overflow");
  a_fault_release_write: assert property ($rose(wd_fault_out_n) |-> s_axi_bvalid)
    else $error("fault output released without a write");
  a_req_after_hold: assert property ($rose(wd_chip_reset_req) |->
    lowCnt >= 6'h10 && lowCnt <= 6'h28 && lowCnt == 6'(2 * HOLD_STATES))
    else $error("chip reset request outside hold window");
  a_req_needs_fault: assert property (wd_chip_reset_req |-> !wd_fault_out_n)
    else $error("chip reset request without fault");
  a_first_irq_late: assert property (wd_irq |-> sinceRst >= 17'h0FF00)
    else $error("overflow earlier than shortest detection time");
  a_start_quiet: assert property ($rose(arst_n) |-> wd_fault_out_n && !wd_chip_reset_req)
    else $error("outputs not idle after reset release");
  a_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");

  c_overflow: cover property (wd_irq);
  c_chip_reset: cover property ($rose(wd_chip_reset_req));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule : rwd_watchdog_monitor

bind rwd_watchdog rwd_watchdog_monitor #(.HOLD_STATES(HOLD_STATES)) mon_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .wd_irq(wd_irq),
  .wd_fault_out_n(wd_fault_out_n), .wd_chip_reset_req(wd_chip_reset_req));

`default_nettype wire

// >>> bench/rwd_peripheral.sv
`timescale 1ns/1ps
`default_nettype none

module rwd_peripheral (
  // clock and bench reset
  input wire logic clk_sys,
  input wire logic benchRst_n,
  // from the watchdog
  input wire logic wd_fault_out_n,
  input wire logic wd_chip_reset_req,
  // to the chip and observation
  output logic chipRst_n,
  output logic [3:0] faultSeen
);
  logic [2:0] holdCnt;
  logic lastFault;

  // registered so the request never meets its own async clear as a glitch
  always_ff @(posedge clk_sys or negedge benchRst_n) begin
    if (!benchRst_n) holdCnt <= 3'h0;
    else if (wd_chip_reset_req) holdCnt <= 3'h4;
    else if (holdCnt != 3'h0) holdCnt <= holdCnt - 3'h1;
  end

  // peripherals count each fault that would reset them
  always_ff @(posedge clk_sys or negedge benchRst_n) begin
    if (!benchRst_n) begin
      lastFault <= 1'b1;
      faultSeen <= 4'h0;
    end else begin
      lastFault <= wd_fault_out_n;
      if (lastFault && !wd_fault_out_n) faultSeen <= faultSeen + 4'h1;
    end
  end

  assign chipRst_n = benchRst_n && holdCnt == 3'h0;
endmodule : rwd_peripheral

`default_nettype wire

// >>> bench/rwd_watchdog_bench.sv
`timescale 1ns/1ps
`default_nettype none

`include "rwd_defs.svh"

module rwd_watchdog_bench;
  logic clk_sys, benchRst_n, chipRst_n, standby, busAckN, irq, faultN, resetReq;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, gotData, prevCount;
  logic [1:0] bResp, rResp, gotResp;
  logic [3:0] faultSeen;
  int fail_count, total_checks, cycles, n;
  logic held;

  rwd_watchdog dut_u (.clk_sys(clk_sys), .arst_n(chipRst_n),
    .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .standby_mode(standby), .bus_grant_ack_n(busAckN),
    .wd_irq(irq), .wd_fault_out_n(faultN), .wd_chip_reset_req(resetReq));

  rwd_peripheral peer_u (.clk_sys(clk_sys), .benchRst_n(benchRst_n), .wd_fault_out_n(faultN),
    .wd_chip_reset_req(resetReq), .chipRst_n(chipRst_n), .faultSeen(faultSeen));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task end_sim;
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // one overflow at the shortest tap plus setup fits well inside this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      end_sim();
    end
  end

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task ok(input string what, input logic cond);
    check(what, 32'h1, {31'h0, cond});
  endtask : ok

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    gotResp = bResp;
    bReady <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arValid && arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    gotData = rData;
    gotResp = rResp;
    rReady <= 1'b0;
  endtask : rd

  task t_reset_values;
    rd(`RWD_MODE_OFFSET);
    check("mode reset", {24'h0, `RWD_MODE_RESET}, gotData);
    rd(`RWD_STATUS_OFFSET);
    ok("active after reset", gotData[0]);
    rd(`RWD_COMMAND_OFFSET);
    check("command read", 32'h0, gotData);
    rd(12'h010);
    check("unmapped resp", {30'h0, `RWD_RESP_SLVERR}, {30'h0, gotResp});
    check("unmapped data", 32'h0, gotData);
  endtask : t_reset_values

  task t_codes;
    rd(`RWD_COUNT_OFFSET);
    prevCount = gotData;
    wr(`RWD_COMMAND_OFFSET, 32'h55);
    rd(`RWD_COUNT_OFFSET);
    ok("count kept", gotData > prevCount);
    wr(`RWD_COMMAND_OFFSET, {24'h0, `RWD_CODE_CLEAR});
    rd(`RWD_COUNT_OFFSET);
    ok("count cleared", gotData < 32'h8);
    rd(`RWD_STATUS_OFFSET);
    ok("still active", gotData[0]);
  endtask : t_codes

  task t_disable;
    wr(`RWD_COMMAND_OFFSET, {24'h0, `RWD_CODE_DISABLE});
    rd(`RWD_STATUS_OFFSET);
    ok("code alone ignored", gotData[0]);
    wr(`RWD_MODE_OFFSET, 32'h62);
    rd(`RWD_MODE_OFFSET);
    check("mode written", 32'h62, gotData);
    wr(`RWD_COMMAND_OFFSET, {24'h0, `RWD_CODE_DISABLE});
    rd(`RWD_STATUS_OFFSET);
    ok("disabled", gotData[0] === 1'b0);
    prevCount = gotData;
    rd(`RWD_COUNT_OFFSET);
    prevCount = gotData;
    rd(`RWD_COUNT_OFFSET);
    ok("runs disabled", gotData > prevCount);
    wr(`RWD_COMMAND_OFFSET, {24'h0, `RWD_CODE_CLEAR});
    wr(`RWD_MODE_OFFSET, 32'h80);
    rd(`RWD_STATUS_OFFSET);
    ok("re-enabled", gotData[0]);
  endtask : t_disable

  task t_bus_standby;
    @(posedge clk_sys);
    busAckN <= 1'b0;
    rd(`RWD_COUNT_OFFSET);
    prevCount = gotData;
    rd(`RWD_COUNT_OFFSET);
    ok("runs bus released", gotData > prevCount);
    rd(`RWD_STATUS_OFFSET);
    ok("bus release seen", gotData[4]);
    busAckN <= 1'b1;
    standby <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(`RWD_COUNT_OFFSET);
    check("standby clears", 32'h0, gotData);
    rd(`RWD_COUNT_OFFSET);
    check("standby halts", 32'h0, gotData);
    rd(`RWD_STATUS_OFFSET);
    ok("standby seen", gotData[2]);
    standby <= 1'b0;
  endtask : t_bus_standby

  task t_overflow;
    wr(`RWD_MODE_OFFSET, 32'h82);
    wr(`RWD_COMMAND_OFFSET, {24'h0, `RWD_CODE_CLEAR});
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge clk_sys);
      n++;
    end
    ok("overflow time", n >= 65520 && n <= 65540);
    wr(`RWD_COMMAND_OFFSET, {24'h0, `RWD_CODE_CLEAR});
    ok("fault low", faultN === 1'b0);
    n = 0;
    held = 1'b1;
    while (resetReq !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      if (faultN !== 1'b0) held = 1'b0;
      n++;
    end
    ok("hold length", n >= 12 && n <= 40);
    ok("fault held", held);
    check("peripheral reset", 32'h1, {28'h0, faultSeen});
    repeat (10) @(posedge clk_sys);
    rd(`RWD_MODE_OFFSET);
    check("mode after chip reset", {24'h0, `RWD_MODE_RESET}, gotData);
    ok("fault released", faultN === 1'b1);
    rd(`RWD_COUNT_OFFSET);
    ok("count from zero", gotData < 32'h10);
  endtask : t_overflow

  initial begin
    {benchRst_n, standby, awValid, wValid, bReady, arValid, rReady} = '0;
    busAckN = 1'b1;
    awAddr = 12'h000;
    arAddr = 12'h000;
    wData = 32'h0;
    repeat (20) @(posedge clk_sys);
    benchRst_n <= 1'b1;
    t_reset_values();
    t_codes();
    t_disable();
    t_bus_standby();
    t_overflow();
    end_sim();
  end
endmodule : rwd_watchdog_bench

`default_nettype wire
